/* File: inc/mcc_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define MCC_OFS_PRESCALE   12'h000
`define MCC_OFS_IRQ_OUT_EN 12'h004
`define MCC_OFS_GLOBAL     12'h008
`define MCC_OFS_COMMAND    12'h00c
`define MCC_OFS_STATUS     12'h010
`define MCC_OFS_MASK       12'h014
`define MCC_CNT_PAGE       4'h1
`define MCC_SUB_MODE       2'h0
`define MCC_SUB_LOAD       2'h1
`define MCC_SUB_CMP        2'h2
`define MCC_SUB_STATE      2'h3

// ****************************************
// Field positions and codes
// ****************************************
`define MCC_NUM_NARROW     5
`define MCC_GCW_CMP_ON     3
`define MCC_GCW_DECADE     15
`define MCC_IEN_ERR        0
`define MCC_IEN_CNT        8
`define MCC_OUT_PULSE      3'h1
`define MCC_OUT_OFF        3'h0
`define MCC_PERIODIC       3'h1
`define MCC_GATE_NONE      3'h0
`define MCC_WIDE_EDGE_A    3'h1
`define MCC_SRC_EXT_LO     4'h1
`define MCC_SRC_EXT_HI     4'h5
`define MCC_SRC_FAST       4'hd
`define MCC_SRC_SLOW       4'he
`define MCC_DECADE_LAST    4'h9

// ****************************************
// Reset values and timing
// ****************************************
`define MCC_RST_WORD       32'h0000_0000
`define MCC_CLK_PERIOD_NS  8
`define MCC_BASE_PERIOD_NS 1000
`define MCC_BASE_DIV       (`MCC_BASE_PERIOD_NS / `MCC_CLK_PERIOD_NS)

`endif

/* File: inc/mcc_pkg.sv */
// Shared types of the counter bank
`default_nettype none
package mcc_pkg;
  typedef logic [15:0] mcc_word_t;
  typedef logic [31:0] mcc_wide_t;
  typedef logic [14:0] mcc_stat_t;
endpackage
`default_nettype wire

/* File: rtl/mcc_prescale.sv */
// Base clock divider, prescaler and decade stages for reference ticks
`default_nettype none
`include "mcc_map.svh"
module mcc_prescale (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire mcc_pkg::mcc_word_t ratio,
  input  wire logic            decade,
  output logic                 fast_tick,
  output logic                 slow_tick
);
  logic [6:0]  base_cnt;
  logic [15:0] pre_cnt;
  logic [15:0] pre_last;
  logic [3:0]  dec_cnt [3];
  logic [3:0]  tick;
  logic        base_tick;

  // ****************************************
  // 1 MHz base and prescaler
  // ****************************************
  assign base_tick = base_cnt == 7'(`MCC_BASE_DIV - 1);
  assign pre_last  = (ratio == 16'h0000) ? 16'h0000 : ratio - 16'h0001;
  assign tick[0]   = base_tick & (pre_cnt == pre_last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_cnt <= 7'h00;
      pre_cnt  <= 16'h0000;
    end else begin
      base_cnt <= base_tick ? 7'h00 : base_cnt + 7'h01;
      if (base_tick)
        pre_cnt <= tick[0] ? 16'h0000 : pre_cnt + 16'h0001;
    end
  end

  // ****************************************
  // Divide-by-ten stages
  // ****************************************
  for (genvar k = 0; k < 3; k++) begin : g_dec
    assign tick[k+1] = tick[k] & (dec_cnt[k] == `MCC_DECADE_LAST);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        dec_cnt[k] <= 4'h0;
      else if (tick[k])
        dec_cnt[k] <= tick[k+1] ? 4'h0 : dec_cnt[k] + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_tick <= 1'b0;
      slow_tick <= 1'b0;
    end else begin
      fast_tick <= decade ? tick[2] : tick[0];
      slow_tick <= decade ? tick[3] : tick[1];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_slow_on_fast: assert property (slow_tick |-> fast_tick)
    else $error("slow reference tick without fast tick");
endmodule
`default_nettype wire

/* File: rtl/mcc_counter.sv */
// One up/down counter with reload, BCD stepping and compare match
`default_nettype none
`include "mcc_map.svh"
module mcc_counter #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         step,
  input  wire logic         up,
  input  wire logic         bcd,
  input  wire logic         periodic,
  input  wire logic         load,
  input  wire logic         clear,
  input  wire logic         cmp_en,
  input  wire logic [W-1:0] load_val,
  input  wire logic [W-1:0] cmp_val,
  output logic      [W-1:0] state,
  output logic              match,
  output logic              wrap
);
  logic [W-1:0] state_reg;
  logic [W-1:0] state_next;
  logic [W-1:0] stepped;
  logic         run_reg;
  logic         terminal;
  logic         advance;

  function automatic logic [W-1:0] bcd_step(input logic [W-1:0] v,
                                            input logic inc);
    logic [W-1:0] r;
    logic         c;
    logic [3:0]   d;
    r = v;
    c = 1'b1;
    for (int i = 0; i < W / 4; i++) begin
      d = v[4*i +: 4];
      if (c && inc) begin
        c = (d == `MCC_DECADE_LAST);
        d = c ? 4'h0 : d + 4'h1;
      end else if (c) begin
        c = (d == 4'h0);
        d = c ? `MCC_DECADE_LAST : d - 4'h1;
      end
      r[4*i +: 4] = d;
    end
    return r;
  endfunction

  assign terminal = up ? (state_reg == (bcd ? {W/4{4'h9}} : {W{1'b1}}))
                       : (state_reg == '0);
  assign advance  = step & run_reg & ~load & ~clear;
  assign stepped  = bcd ? bcd_step(state_reg, up)
                  : up ? state_reg + W'(1) : state_reg - W'(1);

  always_comb begin
    state_next = state_reg;
    if (clear)
      state_next = '0;
    else if (load)
      state_next = load_val;
    else if (advance && terminal && periodic)
      state_next = load_val;
    else if (advance)
      state_next = stepped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      run_reg   <= 1'b0;
      match     <= 1'b0;
      wrap      <= 1'b0;
    end else begin
      state_reg <= state_next;
      run_reg   <= run_reg | load;
      match     <= advance & cmp_en & (state_next == cmp_val);
      wrap      <= advance & terminal;
    end
  end
  assign state = state_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_plain_down;
    advance && !up && !bcd && !terminal;
  endsequence
  chk_down_step: assert property (
    s_plain_down |=> state_reg == $past(state_reg) - W'(1))
    else $error("down step did not decrement by one");
  chk_period_reload: assert property (
    advance && periodic && terminal |=> state_reg == $past(load_val))
    else $error("periodic reload missed at terminal count");
  chk_load_start: assert property (
    load && !clear |=> state_reg == $past(load_val) && run_reg)
    else $error("load and start failed");
  chk_clear_zero: assert property (clear |=> state_reg == '0)
    else $error("clear did not zero counter");
  chk_bcd_digit: assert property (
    advance && bcd && !up && !terminal && state_reg[3:0] == 4'h0
    |=> state_reg[3:0] == `MCC_DECADE_LAST)
    else $error("bcd low digit did not borrow to nine");
endmodule
`default_nettype wire

/* File: rtl/mcc_top.sv */
// APB counter bank: five 16-bit and two 32-bit counters with compare
// ****************************************
// Overview of operation
// - Base clock divided by prescaler, then tens, gives two reference ticks
// - Interrupt enable bit 0 lets error reports raise the interrupt
// - Interrupt enable bit 8 lets counter events raise the interrupt
// - Interrupt enable bits 9 to 15 enable outputs of counters 1 to 7
// - Narrow mode bits 2:0: 001 gives high pulse, 000 holds output low
// - Narrow mode bit 3 zero counts downward per count pulse
// - Narrow mode bits 7:5 at 001 reload periodically from load register
// - Source bits 11:8: external input, slow or fast reference tick
// - Mode bit 12 zero counts rising edges of the source
// - Gate bits 15:13 at 000 run without gate qualification
// - Wide mode bit 3 enables comparator and output
// - Wide mode bits 6:4 at 001 count input A edges, B gives direction
// - Counter state equal to compare value raises a counter event
// - Load-and-start command copies load register and starts counting
// - Reset command clears addressed counter to zero
// ****************************************
`default_nettype none
`include "mcc_map.svh"
module mcc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  count_in,
  input  wire logic [4:0]  gate_in,
  input  wire logic [1:0]  wide_a,
  input  wire logic [1:0]  wide_b,
  output logic      [6:0]  counter_out,
  output logic             irq
);
  // ****************************************
  // Declarations
  // ****************************************
  mcc_pkg::mcc_word_t prescaler_ratio_reg;
  mcc_pkg::mcc_word_t interrupt_and_output_enable_reg;
  mcc_pkg::mcc_word_t global_control_word_reg;
  mcc_pkg::mcc_word_t mode_reg [7];
  mcc_pkg::mcc_wide_t load_reg [7];
  mcc_pkg::mcc_wide_t cmp_reg  [7];
  mcc_pkg::mcc_wide_t state_all [7];
  mcc_pkg::mcc_stat_t status_reg;
  mcc_pkg::mcc_stat_t status_next;
  mcc_pkg::mcc_stat_t mask_reg;
  mcc_pkg::mcc_stat_t events;
  mcc_pkg::mcc_stat_t w1c;
  logic [31:0] prdata_reg;
  logic [31:0] rd_data;
  logic [6:0]  ld_cmd_reg;
  logic [6:0]  clr_cmd_reg;
  logic [6:0]  match;
  logic [6:0]  wrap;
  logic [6:0]  out_sel;
  logic [6:0]  out_reg;
  logic [4:0]  cin_q;
  logic [4:0]  cin_rise;
  logic [4:0]  cin_fall;
  logic [1:0]  wa_q;
  logic [1:0]  wa_rise;
  logic [2:0]  cidx;
  logic [1:0]  csub;
  logic        access;
  logic        wr_en;
  logic        in_cnt;
  logic        glob_ok;
  logic        addr_ok;
  logic        wr_cnt;
  logic        wr_cmd;
  logic        zero_cmp_wr;
  logic        err_evt;
  logic        err_irq;
  logic        cnt_irq;
  logic        fast_tick;
  logic        slow_tick;

  function automatic logic cnt_hit(input logic [11:0] a);
    return a[11:8] == `MCC_CNT_PAGE && a[7] == 1'b0 && a[6:4] != 3'h7;
  endfunction

  function automatic logic [31:0] width_mask(input logic [2:0] idx);
    return (idx < 3'(`MCC_NUM_NARROW)) ? 32'h0000ffff : 32'hffffffff;
  endfunction

  // ****************************************
  // APB decode
  // ****************************************
  assign access  = psel & penable;
  assign wr_en   = access & pwrite;
  assign in_cnt  = cnt_hit(paddr);
  assign glob_ok = paddr == `MCC_OFS_PRESCALE || paddr == `MCC_OFS_IRQ_OUT_EN
                || paddr == `MCC_OFS_GLOBAL || paddr == `MCC_OFS_COMMAND
                || paddr == `MCC_OFS_STATUS || paddr == `MCC_OFS_MASK;
  assign addr_ok = in_cnt | glob_ok;
  assign cidx    = in_cnt ? paddr[6:4] : 3'h0;
  assign csub    = paddr[3:2];
  assign wr_cnt  = wr_en & cnt_hit(paddr);
  assign wr_cmd  = wr_en & (paddr == `MCC_OFS_COMMAND);
  assign pready  = 1'b1;
  assign pslverr = access & ~addr_ok;
  assign prdata  = prdata_reg;

  // Compare value zero on a narrow counter is reported as an error
  assign zero_cmp_wr = wr_cnt && csub == `MCC_SUB_CMP
                    && cidx < 3'(`MCC_NUM_NARROW) && pwdata[15:0] == 16'h0000;
  assign err_evt = pslverr | zero_cmp_wr;

  always_comb begin
    rd_data = 32'h0000_0000;
    if (in_cnt) begin
      unique case (csub)
        `MCC_SUB_MODE:  rd_data = {16'h0000, mode_reg[cidx]};
        `MCC_SUB_LOAD:  rd_data = load_reg[cidx];
        `MCC_SUB_CMP:   rd_data = cmp_reg[cidx];
        `MCC_SUB_STATE: rd_data = state_all[cidx];
      endcase
    end else if (paddr == `MCC_OFS_PRESCALE) begin
      rd_data = {16'h0000, prescaler_ratio_reg};
    end else if (paddr == `MCC_OFS_IRQ_OUT_EN) begin
      rd_data = {16'h0000, interrupt_and_output_enable_reg};
    end else if (paddr == `MCC_OFS_GLOBAL) begin
      rd_data = {16'h0000, global_control_word_reg};
    end else if (paddr == `MCC_OFS_STATUS) begin
      rd_data = {17'h00000, status_reg};
    end else if (paddr == `MCC_OFS_MASK) begin
      rd_data = {17'h00000, mask_reg};
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata_reg <= `MCC_RST_WORD;
    else if (psel && !penable && !pwrite)
      prdata_reg <= rd_data;
  end

  // ****************************************
  // Global registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_ratio_reg             <= 16'h0000;
      interrupt_and_output_enable_reg <= 16'h0000;
      global_control_word_reg         <= 16'h0000;
      mask_reg                        <= 15'h0000;
    end else if (wr_en) begin
      if (paddr == `MCC_OFS_PRESCALE)
        prescaler_ratio_reg <= pwdata[15:0];
      if (paddr == `MCC_OFS_IRQ_OUT_EN)
        interrupt_and_output_enable_reg <= pwdata[15:0];
      if (paddr == `MCC_OFS_GLOBAL)
        global_control_word_reg <= pwdata[15:0];
      if (paddr == `MCC_OFS_MASK)
        mask_reg <= pwdata[14:0];
    end
  end

  // Command pulses: bits 6:0 load and start, bits 14:8 clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_cmd_reg  <= 7'h00;
      clr_cmd_reg <= 7'h00;
    end else begin
      ld_cmd_reg  <= wr_cmd ? pwdata[6:0] : 7'h00;
      clr_cmd_reg <= wr_cmd ? pwdata[14:8] : 7'h00;
    end
  end

  // ****************************************
  // Per-counter registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 7; i++) begin
        mode_reg[i] <= 16'h0000;
        load_reg[i] <= `MCC_RST_WORD;
        cmp_reg[i]  <= `MCC_RST_WORD;
      end
    end else if (wr_cnt) begin
      if (csub == `MCC_SUB_MODE)
        mode_reg[cidx] <= pwdata[15:0];
      if (csub == `MCC_SUB_LOAD)
        load_reg[cidx] <= pwdata & width_mask(cidx);
      if (csub == `MCC_SUB_CMP)
        cmp_reg[cidx] <= pwdata & width_mask(cidx);
    end
  end

  // ****************************************
  // Reference ticks and input edges
  // ****************************************
  mcc_prescale u_pre (
    .pclk      (pclk),
    .presetn   (presetn),
    .ratio     (prescaler_ratio_reg),
    .decade    (global_control_word_reg[`MCC_GCW_DECADE]),
    .fast_tick (fast_tick),
    .slow_tick (slow_tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cin_q <= 5'h00;
      wa_q  <= 2'h0;
    end else begin
      cin_q <= count_in;
      wa_q  <= wide_a;
    end
  end
  assign cin_rise = count_in & ~cin_q;
  assign cin_fall = ~count_in & cin_q;
  assign wa_rise  = wide_a & ~wa_q;

  // ****************************************
  // Counters
  // ****************************************
  for (genvar i = 0; i < 7; i++) begin : g_cnt
    localparam int W = (i < `MCC_NUM_NARROW) ? 16 : 32;
    logic [W-1:0] st;
    logic         step;
    logic         up;
    logic         bcd;
    logic         per;
    logic         cen;
    if (i < `MCC_NUM_NARROW) begin : g_narrow
      logic [3:0] src;
      logic [2:0] sidx;
      logic       ext_ok;
      logic       pulse;
      logic       gate_ok;
      assign src     = mode_reg[i][11:8];
      assign sidx    = 3'(src - `MCC_SRC_EXT_LO);
      assign ext_ok  = src >= `MCC_SRC_EXT_LO && src <= `MCC_SRC_EXT_HI;
      assign pulse   = (src == `MCC_SRC_FAST) ? fast_tick
                     : (src == `MCC_SRC_SLOW) ? slow_tick
                     : !ext_ok ? 1'b0
                     : mode_reg[i][12] ? cin_fall[sidx]
                     : cin_rise[sidx];
      assign gate_ok = mode_reg[i][15:13] == `MCC_GATE_NONE
                     || gate_in[i];
      assign step    = pulse & gate_ok;
      assign up      = mode_reg[i][3];
      assign bcd     = mode_reg[i][4];
      assign per     = mode_reg[i][7:5] == `MCC_PERIODIC;
      assign cen     = global_control_word_reg[`MCC_GCW_CMP_ON];
      assign out_sel[i] = mode_reg[i][2:0] == `MCC_OUT_PULSE;
    end else begin : g_wide
      assign step = mode_reg[i][6:4] == `MCC_WIDE_EDGE_A
                  && wa_rise[i-5];
      assign up   = wide_b[i-5];
      assign bcd  = 1'b0;
      assign per  = 1'b0;
      assign cen  = global_control_word_reg[`MCC_GCW_CMP_ON]
                  & mode_reg[i][3];
      assign out_sel[i] = mode_reg[i][3];
    end

    mcc_counter #(.W(W)) u_cnt (
      .pclk     (pclk),
      .presetn  (presetn),
      .step     (step),
      .up       (up),
      .bcd      (bcd),
      .periodic (per),
      .load     (ld_cmd_reg[i]),
      .clear    (clr_cmd_reg[i]),
      .cmp_en   (cen),
      .load_val (load_reg[i][W-1:0]),
      .cmp_val  (cmp_reg[i][W-1:0]),
      .state    (st),
      .match    (match[i]),
      .wrap     (wrap[i])
    );
    assign state_all[i] = 32'(st);
  end

  // Output pulse on compare match, gated per counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      out_reg <= 7'h00;
    else
      out_reg <= interrupt_and_output_enable_reg[15:9] & out_sel & match;
  end
  assign counter_out = out_reg;

  // ****************************************
  // Event status and interrupt
  // ****************************************
  assign events      = {wrap, match, err_evt};
  assign w1c         = (wr_en && paddr == `MCC_OFS_STATUS) ? pwdata[14:0]
                                                            : 15'h0000;
  assign status_next = (status_reg & ~w1c) | events;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      status_reg <= 15'h0000;
    else
      status_reg <= status_next;
  end

  assign err_irq = status_reg[0] & mask_reg[0]
                 & interrupt_and_output_enable_reg[`MCC_IEN_ERR];
  assign cnt_irq = (|(status_reg[14:1] & mask_reg[14:1]))
                 & interrupt_and_output_enable_reg[`MCC_IEN_CNT];
  assign irq     = err_irq | cnt_irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_load_one;
    wr_cmd && pwdata[1] && !pwdata[9] ##1 ld_cmd_reg[1];
  endsequence
  sequence s_clear_one;
    wr_cmd && pwdata[9] ##1 clr_cmd_reg[1];
  endsequence

  chk_err_irq: assert property (
    status_reg[0] && mask_reg[0] && interrupt_and_output_enable_reg[0]
    |-> irq)
    else $error("error report did not raise interrupt");
  chk_irq_quiet: assert property (
    !interrupt_and_output_enable_reg[0] && !interrupt_and_output_enable_reg[8]
    |-> !irq)
    else $error("interrupt raised while both classes disabled");
  chk_match_irq: assert property (
    match[5] && mask_reg[6] && interrupt_and_output_enable_reg[8]
    |=> status_reg[6] && irq)
    else $error("compare match did not raise interrupt");
  chk_out_gate: assert property (
    !interrupt_and_output_enable_reg[9] |=> !counter_out[0])
    else $error("counter 1 output active while disabled");
  chk_out_pulse: assert property (
    match[1] && interrupt_and_output_enable_reg[10]
    && mode_reg[1][2:0] == `MCC_OUT_PULSE |=> counter_out[1])
    else $error("pulse output missing on match");
  chk_out_off: assert property (
    mode_reg[2][2:0] == `MCC_OUT_OFF |=> !counter_out[2])
    else $error("switched off output went high");
  chk_wide_cmp: assert property (
    !mode_reg[5][3] |=> !match[5] ##1 !counter_out[5])
    else $error("wide comparator active while disabled");
  chk_load_cmd: assert property (
    s_load_one |=> state_all[1] == $past(load_reg[1]))
    else $error("load command did not copy load register");
  chk_clear_cmd: assert property (
    s_clear_one |=> state_all[1] == 32'h0000_0000)
    else $error("reset command did not clear counter");
  chk_fast_src: assert property (
    mode_reg[3][11:8] == `MCC_SRC_FAST
    && mode_reg[3][15:13] == `MCC_GATE_NONE |-> g_cnt[3].step == fast_tick)
    else $error("fast reference not routed to counter");
endmodule
`default_nettype wire

/* File: bench/mcc_host.sv */
// APB host model that programs and reads the counter bank
`default_nettype none
module mcc_host (
  input  wire logic        pclk,
  output logic      [11:0] paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic err;
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
    err = 1'b0;
  end
  // Setup, access until ready, release, one idle edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* File: bench/test_mcc_top.sv */
// Self-checking bench of the counter bank over APB
`default_nettype none
`include "mcc_map.svh"
module test_mcc_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] C1 = 12'h100, C2 = 12'h110, C3 = 12'h120;
  localparam logic [11:0] C4 = 12'h130, C6 = 12'h150;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0]  count_in, gate_in;
  logic [1:0]  wide_a, wide_b;
  logic [6:0]  counter_out;
  int          fails, compares, cycles, pulses, off_pulses;
  mcc_top u_mcc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_in(count_in), .gate_in(gate_in), .wide_a(wide_a),
    .wide_b(wide_b), .counter_out(counter_out), .irq(irq));
  mcc_host u_mcc_host (.pclk(pclk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_mcc_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    u_mcc_host.xfer(1'b0, a, 32'h0000_0000, q);
    check(q, e);
  endtask
  // Rising edges on counter 2 input and wide counter 1 input A
  task automatic edges(input int n);
    repeat (n) begin
      count_in[1] <= 1'b1;
      wide_a[0] <= 1'b1;
      repeat (3) @(posedge pclk);
      count_in[1] <= 1'b0;
      wide_a[0] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask
  task automatic end_of_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (counter_out[1] === 1'b1) pulses++;
    if (counter_out[2] === 1'b1) off_pulses++;
    if (cycles == 10000) begin
      fails++;
      end_of_test();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    count_in = 5'h00;
    gate_in = 5'h00;
    wide_a = 2'h0;
    wide_b = 2'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`MCC_OFS_STATUS, 32'h0000_0000);
    wr(`MCC_OFS_GLOBAL, 32'h0000_0008);
    wr(`MCC_OFS_IRQ_OUT_EN, 32'h0000_ff01);
    wr(`MCC_OFS_PRESCALE, 32'h0000_0001);
    rd(`MCC_OFS_PRESCALE, 32'h0000_0001);
    wr(C2, 32'h0000_0231);
    wr(C2 + 12'h4, 32'hffff_0010);
    rd(C2 + 12'h4, 32'h0000_0010);
    wr(C2 + 12'h8, 32'h0000_0005);
    wr(C6, 32'h0000_0018);
    wr(C6 + 12'h4, 32'h0000_0503);
    wr(C6 + 12'h8, 32'h0000_0500);
    wr(`MCC_OFS_COMMAND, 32'h0000_0022);
    rd(C2 + 12'hc, 32'h0000_0010);
    edges(3);
    rd(C6 + 12'hc, 32'h0000_0500);
    rd(`MCC_OFS_STATUS, 32'h0000_0040);
    check({31'h0, irq}, 32'h0000_0000);
    edges(2);
    rd(C2 + 12'hc, 32'h0000_0005);
    rd(`MCC_OFS_STATUS, 32'h0000_0044);
    check(32'(pulses), 32'h0000_0001);
    wr(`MCC_OFS_MASK, 32'h0000_0044);
    check({31'h0, irq}, 32'h0000_0001);
    wr(`MCC_OFS_IRQ_OUT_EN, 32'h0000_fe01);
    check({31'h0, irq}, 32'h0000_0000);
    wr(`MCC_OFS_IRQ_OUT_EN, 32'h0000_ff01);
    wr(`MCC_OFS_STATUS, 32'h0000_0044);
    check({31'h0, irq}, 32'h0000_0000);
    wide_b[0] <= 1'b1;
    edges(6);
    rd(C2 + 12'hc, 32'h0000_0010);
    rd(C6 + 12'hc, 32'h0000_0504);
    rd(`MCC_OFS_STATUS, 32'h0000_0240);
    check({31'h0, irq}, 32'h0000_0001);
    wr(`MCC_OFS_COMMAND, 32'h0000_0200);
    rd(C2 + 12'hc, 32'h0000_0000);
    rd(12'h0f0, 32'h0000_0000);
    check({31'h0, u_mcc_host.err}, 32'h0000_0001);
    wr(`MCC_OFS_STATUS, 32'h0000_7fff);
    wr(12'h0f4, 32'h0000_0000);
    rd(`MCC_OFS_STATUS, 32'h0000_0001);
    wr(`MCC_OFS_MASK, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0001);
    wr(`MCC_OFS_IRQ_OUT_EN, 32'h0000_ff00);
    check({31'h0, irq}, 32'h0000_0000);
    wr(C3, 32'h0000_0e08);
    wr(C3 + 12'h8, 32'h0000_0001);
    wr(C4, 32'h0000_0d08);
    wr(`MCC_OFS_COMMAND, 32'h0000_000c);
    repeat (2500) @(posedge pclk);
    u_mcc_host.xfer(1'b0, C3 + 12'hc, 32'h0000_0000, q);
    check(32'(q >= 32'd1 && q <= 32'd3), 32'h0000_0001);
    u_mcc_host.xfer(1'b0, C4 + 12'hc, 32'h0000_0000, q);
    check(32'(q >= 32'd19 && q <= 32'd22), 32'h0000_0001);
    check(32'(off_pulses), 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire
